// ### hdl/igb_consts.svh
// Constants for the indexed GPIO bank: ports, keys, register indices, reset values
`ifndef IGB_CONSTS_SVH
`define IGB_CONSTS_SVH
`define IGB_PORT_INDEX 1'b0
`define IGB_PORT_DATA 1'b1
`define IGB_KEY_UNLOCK 8'h87
`define IGB_KEY_EXIT 8'hAA
`define IGB_IDX_LDEV_SEL 8'h07
`define IGB_IDX_PIN_FUNC 8'h2A
`define IGB_IDX_ACTIVATE 8'h30
`define IGB_IDX_PIN_DIR 8'hF0
`define IGB_IDX_PIN_DATA 8'hF1
`define IGB_LDEV_IO_UNIT 8'h07
`define IGB_RST_PIN_DIR 8'hFF
`define IGB_RST_PIN_DATA 8'h00
`define IGB_RST_BYTE 8'h00
`define IGB_ACT_BIT 0
`define IGB_FUNC_ALL 8'hFF
`endif

// ### hdl/igb_pkg.sv
// Types for the indexed GPIO bank
package igb_pkg;
    typedef enum logic [2:0] {
        IGB_LOCKED = 3'h1,
        IGB_HALF = 3'h2,
        IGB_OPEN = 3'h4
    } igb_cfg_e;
    typedef struct packed {
        logic wr;
        logic rd;
        logic port;
        logic [7:0] wdata;
    } igb_req_s;
endpackage : igb_pkg

// ### hdl/igb_gpio_bank.sv
// Indexed GPIO bank: configuration unlock, index/data registers and eight pins
`timescale 1ns/1ns
`include "igb_consts.svh"

// Overview of operation
// - A direction bit of one makes its pin an input and a zero makes it an output.
// - The direction register resets to all ones so every pin starts as an input.
// - The data register resets to all zeros.
// - An output pin's data bit is writable, drives the pin once the bank is routed and activated, and reads back the written value.
// - An input pin's data bit reads the pin level and ignores writes.
module igb_gpio_bank (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire igb_pkg::igb_req_s REQ,
    output logic [7:0] RDATA,
    output logic RVALID,
    input wire logic [7:0] PIN_IN,
    output logic [7:0] PIN_OUT,
    output logic [7:0] PIN_OE
);
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    igb_pkg::igb_cfg_e cfg_r;
    igb_pkg::igb_cfg_e cfg_nxt;
    logic [7:0] index_r;
    logic [7:0] ldev_r;
    logic [7:0] func_r;
    logic [7:0] act_r;
    logic [7:0] dir_r;
    logic [7:0] data_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic [7:0] pin_out_r;
    logic [7:0] pin_oe_r;

    wire idx_wr = REQ.wr && (REQ.port == `IGB_PORT_INDEX);
    wire dat_wr = REQ.wr && (REQ.port == `IGB_PORT_DATA) && (cfg_r == igb_pkg::IGB_OPEN);
    wire dat_rd = REQ.rd && (REQ.port == `IGB_PORT_DATA) && (cfg_r == igb_pkg::IGB_OPEN);
    wire unit_sel = (ldev_r == `IGB_LDEV_IO_UNIT);
    wire unit_wr = dat_wr && unit_sel;
    wire bank_on = act_r[`IGB_ACT_BIT] && (func_r == `IGB_FUNC_ALL);
    // Input bits show the pin, output bits show the latch
    wire [7:0] data_view = (dir_r & PIN_IN) | (~dir_r & data_r);

    // Index decode shared by the write enables, the read mux and the checks
    function automatic logic index_hit(input logic [7:0] idx, input logic [7:0] code);
        return idx == code;
    endfunction : index_hit

    wire sel_ldev = index_hit(index_r, `IGB_IDX_LDEV_SEL);
    wire sel_func = index_hit(index_r, `IGB_IDX_PIN_FUNC);
    wire sel_act = index_hit(index_r, `IGB_IDX_ACTIVATE);
    wire sel_dir = index_hit(index_r, `IGB_IDX_PIN_DIR);
    wire sel_data = index_hit(index_r, `IGB_IDX_PIN_DATA);
    wire key_unlock = idx_wr && index_hit(REQ.wdata, `IGB_KEY_UNLOCK);
    wire key_exit = idx_wr && index_hit(REQ.wdata, `IGB_KEY_EXIT);

    // Unlock needs two keys back to back on the index port
    always_comb begin
        cfg_nxt = cfg_r;
        case (cfg_r)
            igb_pkg::IGB_LOCKED: if (idx_wr && REQ.wdata == `IGB_KEY_UNLOCK) cfg_nxt = igb_pkg::IGB_HALF;
            igb_pkg::IGB_HALF: if (idx_wr) begin
                cfg_nxt = (REQ.wdata == `IGB_KEY_UNLOCK) ? igb_pkg::IGB_OPEN : igb_pkg::IGB_LOCKED;
            end
            igb_pkg::IGB_OPEN: if (idx_wr && REQ.wdata == `IGB_KEY_EXIT) cfg_nxt = igb_pkg::IGB_LOCKED;
            default: cfg_nxt = igb_pkg::IGB_LOCKED;
        endcase
    end

    wire [7:0] rd_mux =
        sel_ldev ? ldev_r :
        !unit_sel ? `IGB_RST_BYTE :
        sel_func ? func_r :
        sel_act ? act_r :
        sel_dir ? dir_r :
        sel_data ? data_view : `IGB_RST_BYTE;

    always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cfg_r <= igb_pkg::IGB_LOCKED;
            index_r <= `IGB_RST_BYTE;
            ldev_r <= `IGB_RST_BYTE;
            func_r <= `IGB_RST_BYTE;
            act_r <= `IGB_RST_BYTE;
        end else begin
            cfg_r <= cfg_nxt;
            if (idx_wr && cfg_r == igb_pkg::IGB_OPEN) index_r <= REQ.wdata;
            if (dat_wr && sel_ldev) ldev_r <= REQ.wdata;
            if (unit_wr && sel_func) func_r <= REQ.wdata;
            if (unit_wr && sel_act) act_r <= REQ.wdata;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            dir_r <= `IGB_RST_PIN_DIR;
            data_r <= `IGB_RST_PIN_DATA;
        end else begin
            if (unit_wr && sel_dir) dir_r <= REQ.wdata;
            // Input bits keep their latch so a later turn to output is glitch free
            if (unit_wr && sel_data) begin
                data_r <= (REQ.wdata & ~dir_r) | (data_r & dir_r);
            end
        end
    end

    // Read answer: one-cycle valid, data held until the next accepted read
    always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_r <= `IGB_RST_BYTE;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= dat_rd;
            if (dat_rd) rdata_r <= rd_mux;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pin_out_r <= `IGB_RST_PIN_DATA;
            pin_oe_r <= `IGB_RST_BYTE;
        end else begin
            pin_out_r <= data_r;
            // Pins stay undriven until the bank is routed and activated
            pin_oe_r <= bank_on ? ~dir_r : `IGB_RST_BYTE;
        end
    end

    assign RDATA = rdata_r;
    assign RVALID = rvalid_r;
    assign PIN_OUT = pin_out_r;
    assign PIN_OE = pin_oe_r;

    dir_reset_a: assert property (@(posedge SYS_CLK)
        $rose(rst_n_r) |-> dir_r == `IGB_RST_PIN_DIR)
        else $error("direction not all ones after reset");
    data_reset_a: assert property (@(posedge SYS_CLK)
        $rose(rst_n_r) |-> data_r == `IGB_RST_PIN_DATA)
        else $error("data not zero after reset");
    oe_follows_dir_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        bank_on && $stable(dir_r) |=> PIN_OE == ~$past(dir_r))
        else $error("output enable disagrees with direction");
    out_drive_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        unit_wr && index_r == `IGB_IDX_PIN_DATA |=> ##1 (PIN_OUT & ~$past(dir_r, 2))
            == ($past(REQ.wdata, 2) & ~$past(dir_r, 2)))
        else $error("output bit not driven with written value");
    input_hold_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        unit_wr && index_r == `IGB_IDX_PIN_DATA |=> (data_r & $past(dir_r))
            == ($past(data_r) & $past(dir_r)))
        else $error("write changed an input bit");
    input_read_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        dat_rd && unit_sel && index_r == `IGB_IDX_PIN_DATA |=> (RDATA & $past(dir_r))
            == ($past(PIN_IN) & $past(dir_r)))
        else $error("input bit did not read pin level");
    func_gate_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        func_r != `IGB_FUNC_ALL |=> PIN_OE == `IGB_RST_BYTE)
        else $error("pins driven without function routing");
    locked_ignore_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        cfg_r != igb_pkg::IGB_OPEN && REQ.port == `IGB_PORT_DATA |=> $stable(dir_r) && !RVALID)
        else $error("data port acted while locked");
    rvalid_answer_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        dat_rd |=> RVALID)
        else $error("accepted read not answered");
    rvalid_refuse_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        !dat_rd |=> !RVALID)
        else $error("read valid without accepted read");
    rdata_hold_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        !dat_rd |=> $stable(RDATA))
        else $error("read data moved without a read");
    key_first_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        cfg_r == igb_pkg::IGB_LOCKED |=> cfg_r != igb_pkg::IGB_OPEN)
        else $error("opened on a single key");
    key_second_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        cfg_r == igb_pkg::IGB_HALF && key_unlock |=> cfg_r == igb_pkg::IGB_OPEN)
        else $error("second key did not open");
    key_wrong_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        cfg_r == igb_pkg::IGB_HALF && idx_wr && !key_unlock |=> cfg_r == igb_pkg::IGB_LOCKED)
        else $error("broken key sequence did not relock");
    key_exit_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        cfg_r == igb_pkg::IGB_OPEN && key_exit |=> cfg_r == igb_pkg::IGB_LOCKED)
        else $error("exit key did not lock");
    index_locked_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        cfg_r != igb_pkg::IGB_OPEN |=> $stable(index_r))
        else $error("index moved while locked");
    dir_write_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        unit_wr && sel_dir |=> dir_r == $past(REQ.wdata))
        else $error("direction write not taken");
    dir_read_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        dat_rd && unit_sel && sel_dir |=> RDATA == $past(dir_r))
        else $error("direction read wrong");
    input_undriven_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        bank_on |=> (PIN_OE & $past(dir_r)) == `IGB_RST_BYTE)
        else $error("input pin driven");
    out_read_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        dat_rd && unit_sel && sel_data |=> (RDATA & ~$past(dir_r)) == ($past(data_r) & ~$past(dir_r)))
        else $error("output bit did not read back latch");
    out_latch_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        bank_on |=> PIN_OUT == $past(data_r))
        else $error("pin output lost the latch value");
    act_gate_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        !act_r[`IGB_ACT_BIT] |=> PIN_OE == `IGB_RST_BYTE)
        else $error("pins driven while not activated");
    ldev_read_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        dat_rd && sel_ldev |=> RDATA == $past(ldev_r))
        else $error("device select read wrong");
    unit_gate_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        dat_wr && !unit_sel |=> $stable(dir_r) && $stable(data_r) && $stable(func_r))
        else $error("register written with another device selected");
    foreign_read_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        dat_rd && !unit_sel && !sel_ldev |=> RDATA == `IGB_RST_BYTE)
        else $error("register read with another device selected");
    func_read_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        dat_rd && unit_sel && sel_func |=> RDATA == $past(func_r))
        else $error("pin function read wrong");
    act_read_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_r)
        dat_rd && unit_sel && sel_act |=> RDATA == $past(act_r))
        else $error("activate read wrong");
endmodule : igb_gpio_bank

// ### verification/igb_pin_header.sv
// Model of the external header wired to the eight bank pins
`timescale 1ns/1ns
module igb_pin_header (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_in
);
    // Released bits show the far side, so a missed drive is seen, not masked
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : igb_pin_header

// ### verification/indexed_gpio_bank_tb_top.sv
// Self-checking bench for the indexed GPIO bank
`timescale 1ns/1ns
`include "igb_consts.svh"
module indexed_gpio_bank_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    igb_pkg::igb_req_s req = '0;
    logic [7:0] rdata, pin_out, pin_oe, pin_in;
    logic rvalid;
    logic [7:0] ext_level = 8'hA5;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    // Rows: index, written value, value read back
    logic [23:0] rows [7] = '{24'h2AFFFF, 24'h300101, 24'hF00F0F, 24'hF1F0F5,
        24'hF10F05, 24'hF00000, 24'hF13C3C};
    always #4 clk = ~clk;
    igb_gpio_bank dut_u (.SYS_CLK(clk), .RST_N(rst_n), .REQ(req), .RDATA(rdata),
        .RVALID(rvalid), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe));
    igb_pin_header hdr_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_in(pin_in));
    task automatic results();
        if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // Leaves the strobe up; the next call replaces it, the caller drops it
    task automatic wr(input logic port, input logic [7:0] d);
        req = '{1'b1, 1'b0, port, d};
        @(posedge clk);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] exp, input logic vld);
        logic seen;
        seen = 1'b0;
        req = '{1'b0, 1'b1, 1'b1, 8'h00};
        @(posedge clk);
        #1;
        req = '0;
        repeat (2) begin
            if (rvalid === 1'b1 && !seen) begin
                seen = 1'b1;
                cmp(rdata, exp);
            end
            @(posedge clk);
            #1;
        end
        cmp({7'h00, seen}, {7'h00, vld});
    endtask : rd
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        rd(8'h00, 1'b0);
        wr(1'b0, `IGB_KEY_UNLOCK);
        wr(1'b0, 8'h00);
        rd(8'h00, 1'b0);
        wr(1'b0, `IGB_KEY_UNLOCK);
        wr(1'b0, `IGB_KEY_UNLOCK);
        wr(1'b0, 8'h07);
        wr(1'b1, 8'h07);
        wr(1'b0, 8'hF0);
        rd(8'hFF, 1'b1);
        wr(1'b0, 8'hF0);
        wr(1'b1, 8'h00);
        wr(1'b0, 8'hF1);
        rd(8'h00, 1'b1);
        cmp(pin_oe, 8'h00);
        wr(1'b0, 8'h07);
        wr(1'b1, 8'h08);
        rd(8'h08, 1'b1);
        wr(1'b0, 8'hF0);
        wr(1'b1, 8'h5A);
        rd(8'h00, 1'b1);
        wr(1'b0, 8'h07);
        wr(1'b1, 8'h07);
        wr(1'b0, 8'hF0);
        rd(8'h00, 1'b1);
        wr(1'b0, 8'h2A);
        wr(1'b1, 8'hFF);
        wr(1'b0, 8'h30);
        wr(1'b1, 8'h01);
        foreach (rows[i]) begin
            wr(1'b0, rows[i][23:16]);
            wr(1'b1, rows[i][15:8]);
            rd(rows[i][7:0], 1'b1);
        end
        cmp(pin_oe, 8'hFF);
        cmp(pin_out, 8'h3C);
        wr(1'b0, 8'hF0);
        wr(1'b1, 8'hFF);
        wr(1'b0, 8'hF1);
        wr(1'b1, 8'h00);
        wr(1'b0, 8'hF0);
        wr(1'b1, 8'h00);
        wr(1'b0, 8'hF1);
        rd(8'h3C, 1'b1);
        wr(1'b0, `IGB_KEY_EXIT);
        req = '0;
        @(posedge clk);
        #1;
        rd(8'h00, 1'b0);
        results();
    end
endmodule : indexed_gpio_bank_tb_top
